/* verilog/cmb_reg_bank.sv */
// Management register bank with its MDIO slave frame engine.
// Assumes MDC far slower than clk, and link_up, an_complete, autoneg source on clk.
//
// Functional notes
// - One storage bit per duplicated function
// - Soft reset reachable at six addresses
// - Correct answers after start-up completes
// - Control at 0x0, resets to 0x1100 with strap low and autoneg source high
// - Bit 15 starts self-clearing soft reset
// - Bit 14 read/write loopback, PCS mirror
// - Speed bits 13, 6 read zero
// - Bit 12 mirrors autoneg enable, read-only
// - Bit 11 power-down, registers stay reachable
// - Power-down reset value from strap pin
// - Bit 10 isolates MAC interface
// - Bit 8 reads one, full duplex
// - Bit 7 collision test reads zero
// - Bit 5 unidirectional reads zero
// - Link latch low, cleared by read
// - Clause 22 frame format, MSB first
`timescale 1ns/1ps
`include "cmb_consts.svh"
module cmb_reg_bank #(
   parameter logic [4:0]  PHY_ADDR        = 5'h00,
   parameter logic [15:0] ID_HIGH         = 16'h1234, // Arbitrary value
   parameter logic [15:0] ID_LOW          = 16'h5678, // Arbitrary value
   parameter int          STARTUP_NS      = `CMB_STARTUP_NS,
   parameter int          STARTUP_CYCLES  = (STARTUP_NS + `CMB_CLK_NS - 1) / `CMB_CLK_NS
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic mdc,
   input  wire logic mdio_i,
   output logic      mdio_o,
   output logic      mdio_oe_n,
   input  wire logic powerdown_strap_pin,
   input  wire logic link_up,
   input  wire logic an_complete,
   input  wire logic autoneg_enable_source,
   output logic      soft_reset_active,
   output logic      local_loopback_enable,
   output logic      soft_power_down,
   output logic      mac_side_isolate
);
   import cmb_pkg::*;

   // ****************************************************
   // State and pin synchronisation
   // ****************************************************
   localparam cmb_bank_t BANK_RST = '{st: CMB_ST_PRE, mdio_oe_n: 1'b1, pd: 1'b1,
                                      lat_ok: 1'b1, default: '0};
   localparam int RST_CNT = (STARTUP_CYCLES > 1) ? STARTUP_CYCLES - 1 : 0;

   cmb_bank_t   q;
   cmb_bank_t   d;
   logic [2:0]  pins_s;
   logic        mdc_s;
   logic        mdio_s;
   logic        strap_s;
   logic        rise;
   logic [12:0] hdr;
   logic [15:0] wdat;
   logic [15:0] ctrl_view;
   logic [15:0] stat_view;
   logic [15:0] rd_val;
   logic        commit;
   logic        stat_read;
   logic        hdr_ok;
   logic        wr_rst;
   logic        wr_loop_en;
   logic        wr_pd_en;
   logic        wr_pd_val;
   logic        wr_iso_en;

   cmb_sync #(
      .WIDTH   (3)
   ) u_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .async_i ({powerdown_strap_pin, mdio_i, mdc}),
      .sync_o  (pins_s)
   );

   assign mdc_s   = pins_s[0];
   assign mdio_s  = pins_s[1];
   assign strap_s = pins_s[2];
   assign rise    = mdc_s & ~q.mdc_prev;
   assign hdr     = {q.shreg[11:0], mdio_s};
   assign wdat    = {q.shreg[14:0], mdio_s};
   assign hdr_ok  = ~hdr[12] | (hdr[11:10] == `CMB_OP_WR) | (hdr[11:10] == `CMB_OP_RD);

   // ****************************************************
   // Register views
   // ****************************************************
   always_comb begin
      ctrl_view = '0;
      ctrl_view[`CMB_B_RST]     = q.soft_rst;
      ctrl_view[`CMB_B_LOOP]    = q.loop;
      ctrl_view[`CMB_B_SPD_LO]  = 1'b0;
      ctrl_view[`CMB_B_AUTONEG_ENABLE_SOURCE]   = autoneg_enable_source;
      ctrl_view[`CMB_B_PD]      = q.pd;
      ctrl_view[`CMB_B_ISO]     = q.iso;
      ctrl_view[`CMB_B_DUPLEX]  = 1'b1;
      ctrl_view[`CMB_B_COLTEST] = 1'b0;
      ctrl_view[`CMB_B_SPD_HI]  = 1'b0;
      ctrl_view[`CMB_B_UNIDIR]  = 1'b0;
      stat_view = `CMB_STAT_FIXED;
      stat_view[`CMB_B_STAT_ANC]  = an_complete;
      stat_view[`CMB_B_STAT_LINK] = q.lat_ok & link_up;
   end

   // Read data for the frame in flight
   always_comb begin
      rd_val = '0;
      if (q.c22) begin
         case (q.reg_dev)
            `CMB_C22_CTRL:    rd_val = ctrl_view;
            `CMB_C22_STAT:    rd_val = stat_view;
            `CMB_C22_ID_HI:   rd_val = ID_HIGH;
            `CMB_C22_ID_LO:   rd_val = ID_LOW;
            `CMB_C22_IA_CTRL: rd_val = q.ia_ctrl;
            `CMB_C22_IA_DATA: rd_val = q.ia_data;
            default:          rd_val = '0;
         endcase
      end else begin
         case ({q.reg_dev, q.mmd_addr})
            {`CMB_DEV_PMA, `CMB_A_CTRL1}: begin
               rd_val[`CMB_B_RST] = q.soft_rst;
               rd_val[`CMB_B_PD]  = q.pd;
            end
            {`CMB_DEV_PMA, `CMB_A_PMA_CTRL}: begin
               rd_val[`CMB_B_RST] = q.soft_rst;
            end
            {`CMB_DEV_PCS, `CMB_A_CTRL1}: begin
               rd_val[`CMB_B_RST]  = q.soft_rst;
               rd_val[`CMB_B_LOOP] = q.loop;
               rd_val[`CMB_B_PD]   = q.pd;
            end
            {`CMB_DEV_PCS, `CMB_A_PCS_CTRL}: begin
               rd_val[`CMB_B_RST]  = q.soft_rst;
               rd_val[`CMB_B_LOOP] = q.loop;
            end
            {`CMB_DEV_VEND1, `CMB_A_VEND_RST}: begin
               rd_val[`CMB_B_VEND] = q.soft_rst;
            end
            {`CMB_DEV_VEND1, `CMB_A_VEND_PD}: begin
               rd_val[`CMB_B_VEND] = q.pd;
            end
            default: rd_val = '0;
         endcase
      end
   end

   // ****************************************************
   // Write decode
   // ****************************************************
   assign commit    = rise & (q.st == CMB_ST_DATA) & (q.cnt == `CMB_DATA_LAST) & ~q.rd & q.hit;
   assign stat_read = rise & (q.st == CMB_ST_TA) & (q.cnt == 6'h01) & q.rd & q.hit & q.c22
                      & (q.reg_dev == `CMB_C22_STAT);

   always_comb begin
      wr_rst     = 1'b0;
      wr_loop_en = 1'b0;
      wr_pd_en   = 1'b0;
      wr_pd_val  = wdat[`CMB_B_PD];
      wr_iso_en  = 1'b0;
      if (q.c22) begin
         if (q.reg_dev == `CMB_C22_CTRL) begin
            wr_rst     = wdat[`CMB_B_RST];
            wr_loop_en = 1'b1;
            wr_pd_en   = 1'b1;
            wr_iso_en  = 1'b1;
         end
      end else if (q.op == `CMB_OP_WR) begin
         case ({q.reg_dev, q.mmd_addr})
            {`CMB_DEV_PMA, `CMB_A_CTRL1}: begin
               wr_rst   = wdat[`CMB_B_RST];
               wr_pd_en = 1'b1;
            end
            {`CMB_DEV_PMA, `CMB_A_PMA_CTRL}: wr_rst = wdat[`CMB_B_RST];
            {`CMB_DEV_PCS, `CMB_A_CTRL1}: begin
               wr_rst     = wdat[`CMB_B_RST];
               wr_loop_en = 1'b1;
               wr_pd_en   = 1'b1;
            end
            {`CMB_DEV_PCS, `CMB_A_PCS_CTRL}: begin
               wr_rst     = wdat[`CMB_B_RST];
               wr_loop_en = 1'b1;
            end
            {`CMB_DEV_VEND1, `CMB_A_VEND_RST}: wr_rst = wdat[`CMB_B_VEND];
            {`CMB_DEV_VEND1, `CMB_A_VEND_PD}: begin
               wr_pd_en  = 1'b1;
               wr_pd_val = wdat[`CMB_B_VEND];
            end
            default: wr_rst = 1'b0;
         endcase
      end
   end

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      d = q;
      d.mdc_prev = mdc_s;
      if (q.strap_cnt != 2'h3) begin
         d.strap_cnt = q.strap_cnt + 2'h1;
         if (q.strap_cnt == 2'h2) begin
            d.strap_val = strap_s;
            d.pd        = strap_s;
         end
      end
      d.lat_ok = (stat_read ? 1'b1 : q.lat_ok) & link_up;
      if (rise) begin
         case (q.st)
            CMB_ST_PRE: begin
               if (mdio_s) begin
                  if (q.cnt != `CMB_PRE_BITS) begin
                     d.cnt = q.cnt + 6'h01;
                  end
               end else if (q.cnt == `CMB_PRE_BITS) begin
                  d.st  = CMB_ST_HDR;
                  d.cnt = '0;
               end else begin
                  d.cnt = '0;
               end
            end
            CMB_ST_HDR: begin
               d.shreg = wdat;
               d.cnt   = q.cnt + 6'h01;
               if (q.cnt == `CMB_HDR_LAST) begin
                  d.c22     = hdr[12];
                  d.op      = hdr[11:10];
                  d.hit     = (hdr[9:5] == PHY_ADDR);
                  d.reg_dev = hdr[4:0];
                  d.rd      = hdr[12] ? (hdr[11:10] == `CMB_OP_RD) : hdr[11];
                  d.st      = hdr_ok ? CMB_ST_TA : CMB_ST_PRE;
                  d.cnt     = '0;
               end
            end
            CMB_ST_TA: begin
               d.cnt = q.cnt + 6'h01;
               if (q.cnt == 6'h00) begin
                  if (q.rd && q.hit) begin
                     d.mdio_o    = 1'b0;
                     d.mdio_oe_n = 1'b0;
                  end
               end else begin
                  d.st  = CMB_ST_DATA;
                  d.cnt = '0;
                  if (q.rd && q.hit) begin
                     d.shreg  = rd_val;
                     d.mdio_o = rd_val[15];
                  end
               end
            end
            CMB_ST_DATA: begin
               d.shreg = q.rd ? {q.shreg[14:0], 1'b0} : wdat;
               d.cnt   = q.cnt + 6'h01;
               if (q.rd && q.hit) begin
                  d.mdio_o = q.shreg[14];
               end
               if (q.cnt == `CMB_DATA_LAST) begin
                  d.st        = CMB_ST_PRE;
                  d.cnt       = '0;
                  d.mdio_o    = 1'b0;
                  d.mdio_oe_n = 1'b1;
                  if (!q.c22 && q.op == `CMB_OP_RD_INC && q.hit) begin
                     d.mmd_addr = q.mmd_addr + 16'h0001;
                  end
               end
            end
            default: begin
               d.st        = CMB_ST_PRE;
               d.mdio_oe_n = 1'b1;
            end
         endcase
      end
      if (q.soft_rst) begin
         if (q.rst_cnt == 16'h0000) begin
            d.soft_rst = 1'b0;
            d.loop     = 1'b0;
            d.iso      = 1'b0;
            d.pd       = q.strap_val;
            d.ia_ctrl  = `CMB_IA_RST;
            d.ia_data  = `CMB_IA_RST;
            d.mmd_addr = '0;
            d.lat_ok   = link_up;
         end else begin
            d.rst_cnt = q.rst_cnt - 16'h0001;
         end
      end else if (commit) begin
         if (q.c22 && q.reg_dev == `CMB_C22_IA_CTRL) begin
            d.ia_ctrl = wdat;
         end
         if (q.c22 && q.reg_dev == `CMB_C22_IA_DATA) begin
            d.ia_data = wdat;
         end
         if (!q.c22 && q.op == 2'h0) begin
            d.mmd_addr = wdat;
         end
         if (wr_loop_en) begin
            d.loop = wdat[`CMB_B_LOOP];
         end
         if (wr_pd_en) begin
            d.pd = wr_pd_val;
         end
         if (wr_iso_en) begin
            d.iso = wdat[`CMB_B_ISO];
         end
         if (wr_rst) begin
            d.soft_rst = 1'b1;
            d.rst_cnt  = 16'(RST_CNT);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= BANK_RST;
      end else begin
         q <= d;
      end
   end

   assign mdio_o                = q.mdio_o;
   assign mdio_oe_n             = q.mdio_oe_n;
   assign soft_reset_active     = q.soft_rst;
   assign local_loopback_enable = q.loop;
   assign soft_power_down       = q.pd;
   assign mac_side_isolate      = q.iso;

   // ****************************************************
   // Assertions
   // ****************************************************
   // Length of the running soft reset
   logic [15:0] a_rst_len_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_rst_len_q <= '0;
      end else begin
         a_rst_len_q <= q.soft_rst ? a_rst_len_q + 16'h0001 : 16'h0000;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_ta_first;
      rise && q.st == CMB_ST_TA && q.cnt == 6'h00 && q.rd && q.hit;
   endsequence
   sequence s_rst_write;
      commit && wr_rst && !q.soft_rst;
   endsequence

   a_speed_bits_zero: assert property (!ctrl_view[13] && !ctrl_view[6])
      else $error("speed select bits not zero");
   a_fixed_ctrl_bits: assert property (ctrl_view[8] && !ctrl_view[7] && !ctrl_view[5])
      else $error("fixed duplex, collision or unidirectional bit wrong");
   a_reserved_zero: assert property (!ctrl_view[9] && ctrl_view[4:0] == 5'h00)
      else $error("reserved control bits not zero");
   a_autoneg_view: assert property (ctrl_view[12] == autoneg_enable_source)
      else $error("autoneg view differs from source");
   a_rst_write_set: assert property (s_rst_write |=> q.soft_rst [*2])
      else $error("soft reset write not taken");
   a_rst_self_clear: assert property (a_rst_len_q <= 16'(STARTUP_CYCLES))
      else $error("soft reset did not clear");
   a_rst_defaults: assert property ($fell(q.soft_rst) |-> !q.loop && !q.iso && q.pd == q.strap_val)
      else $error("control defaults not restored after soft reset");
   a_ta_drive_low: assert property (s_ta_first |=> !mdio_oe_n && !mdio_o)
      else $error("turnaround zero not driven");
   a_idle_release: assert property (q.st == CMB_ST_PRE |-> mdio_oe_n)
      else $error("mdio driven outside a read");
   a_link_latch: assert property (!link_up |=> !q.lat_ok)
      else $error("link latch not cleared on link loss");
   a_latch_hold: assert property (!q.lat_ok && !stat_read && !q.soft_rst |=> !q.lat_ok)
      else $error("link latch released without a status read");

endmodule // cmb_reg_bank

/* include/cmb_consts.svh */
// Constants of the management register bank: addresses, bit positions, reset values, timing.
// Assumes inclusion by bare name from the design files.
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH

// ****************************************************
// Clause 22 register addresses
// ****************************************************
`define CMB_C22_CTRL      5'h00
`define CMB_C22_STAT      5'h01
`define CMB_C22_ID_HI     5'h02
`define CMB_C22_ID_LO     5'h03
`define CMB_C22_IA_CTRL   5'h0D
`define CMB_C22_IA_DATA   5'h0E

// ****************************************************
// Clause 45 device and register addresses
// ****************************************************
`define CMB_DEV_PMA       5'h01
`define CMB_DEV_PCS       5'h03
`define CMB_DEV_VEND1     5'h1E
`define CMB_A_CTRL1       16'h0000
`define CMB_A_PMA_CTRL    16'h08F6
`define CMB_A_PCS_CTRL    16'h08E6
`define CMB_A_VEND_RST    16'h8810
`define CMB_A_VEND_PD     16'h8812

// ****************************************************
// Control and status register bit positions
// ****************************************************
`define CMB_B_RST         15
`define CMB_B_LOOP        14
`define CMB_B_SPD_LO      13
`define CMB_B_AUTONEG_ENABLE_SOURCE       12
`define CMB_B_PD          11
`define CMB_B_ISO         10
`define CMB_B_DUPLEX      8
`define CMB_B_COLTEST     7
`define CMB_B_SPD_HI      6
`define CMB_B_UNIDIR      5
`define CMB_B_VEND        0
`define CMB_B_STAT_ANC    5
`define CMB_B_STAT_LINK   2

// ****************************************************
// Reset values and frame fields
// ****************************************************
`define CMB_CTRL_RST      16'h1100
`define CMB_STAT_FIXED    16'h1009
`define CMB_IA_RST        16'h0000
`define CMB_OP_WR         2'h1
`define CMB_OP_RD         2'h2
`define CMB_OP_RD_INC     2'h2
`define CMB_PRE_BITS      6'h20
`define CMB_HDR_LAST      6'h0C
`define CMB_DATA_LAST     6'h0F

// ****************************************************
// Timing
// ****************************************************
`define CMB_CLK_NS        20
`define CMB_STARTUP_NS    2000

`endif

/* include/cmb_pkg.sv */
// Types of the management register bank.
// Assumes nothing of its surroundings.
package cmb_pkg;

   // ****************************************************
   // Frame engine states, Gray coded
   // ****************************************************
   typedef enum logic [1:0] {
      CMB_ST_PRE  = 2'h0,
      CMB_ST_HDR  = 2'h1,
      CMB_ST_TA   = 2'h3,
      CMB_ST_DATA = 2'h2
   } cmb_mdio_st_t;

   // ****************************************************
   // Whole state of the register bank
   // ****************************************************
   typedef struct packed {
      cmb_mdio_st_t st;
      logic [5:0]   cnt;
      logic [15:0]  shreg;
      logic [1:0]   op;
      logic         c22;
      logic         rd;
      logic         hit;
      logic [4:0]   reg_dev;
      logic [15:0]  mmd_addr;
      logic [15:0]  ia_ctrl;
      logic [15:0]  ia_data;
      logic         soft_rst;
      logic [15:0]  rst_cnt;
      logic         loop;
      logic         pd;
      logic         iso;
      logic         lat_ok;
      logic [1:0]   strap_cnt;
      logic         strap_val;
      logic         mdc_prev;
      logic         mdio_o;
      logic         mdio_oe_n;
   } cmb_bank_t;

endpackage

/* verilog/cmb_sync.sv */
// Two flip-flop synchroniser for pin inputs.
// Assumes inputs asynchronous to clk; the first stage feeds only the second.
`timescale 1ns/1ps
module cmb_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   import cmb_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } cmb_sync_t;

   cmb_sync_t q;
   cmb_sync_t d;

   always_comb begin
      d    = q;
      d.s1 = async_i;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.s2;

endmodule // cmb_sync

/* dv/cmb_sta_model.sv */
// Station manager model that drives MDC and frames on the MDIO wire.
// Assumes the bench resolves the pulled-up wire; calls start at a falling clk edge.
`timescale 1ns/1ps
module cmb_sta_model (
   input  wire logic clk,
   output logic      mdc,
   output logic      host_d,
   output logic      host_en,
   input  wire logic mdio_w
);
   // ****************************************************
   // Bit and frame tasks
   // ****************************************************
   logic [16:0] rd_q;
   int          half = 8;

   initial begin
      mdc     = 1'b0;
      host_d  = 1'b1;
      host_en = 1'b0;
      rd_q    = 17'h00000;
   end

   task automatic bit_x(input logic b, input logic en);
      host_d  = b;
      host_en = en;
      mdc     = 1'b0;
      repeat (half) @(negedge clk);
      mdc  = 1'b1;
      rd_q = {rd_q[15:0], mdio_w};
      repeat (half) @(negedge clk);
   endtask

   // Host lets go of the wire from turnaround on for every read op
   task automatic frame(input logic c22, input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ta);
      logic [31:0] hdr;
      hdr = {1'b0, c22, op, pa, ra, 2'b10, wd};
      for (int i = 0; i < 32; i++) bit_x(1'b1, 1'b1);
      for (int i = 31; i >= 0; i--) bit_x(hdr[i], !(op[1] && i < 18));
      rd      = rd_q[15:0];
      ta      = rd_q[16];
      mdc     = 1'b0;
      host_en = 1'b0;
      @(negedge clk);
   endtask
endmodule // cmb_sta_model

/* dv/tb_top.sv */
// Self-checking bench of the management register bank.
// Assumes the station model on a pulled-up MDIO wire.
`timescale 1ns/1ps
`include "cmb_consts.svh"
module tb_top;
   import cmb_pkg::*;
   // ****************************************************
   // Signals, design and partner
   // ****************************************************
   localparam int          SU     = 2600;
   localparam int          LIM    = 100000;
   localparam logic [4:0]  PA     = 5'h05;
   localparam logic [15:0] IDH    = 16'hA5C3; // Arbitrary value
   localparam logic [15:0] IDL    = 16'h3C5A; // Arbitrary value
   localparam logic [4:0]  DV [5] = '{5'h01, 5'h01, 5'h03, 5'h03, 5'h1E};
   localparam logic [15:0] AD [5] = '{16'h0000, 16'h08F6, 16'h0000, 16'h08E6, 16'h8810};
   localparam int          BT [5] = '{15, 15, 15, 15, 0};
   logic   clk, rst_n, mdc, host_d, host_en, mdio_w, mdio_o, mdio_oe_n;
   logic   strap, link_up, an_c, an_src, sra, lpe, spd, msi;
   logic   loop_m, pd_m, iso_m;
   int     miscompares, check_count, cyc;
   integer seed = 32'hd93e;

   assign mdio_w = !mdio_oe_n ? mdio_o : (host_en ? host_d : 1'b1);

   cmb_reg_bank #(.PHY_ADDR(PA), .ID_HIGH(IDH), .ID_LOW(IDL), .STARTUP_CYCLES(SU)) dut_u (
      .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
      .mdio_oe_n(mdio_oe_n), .powerdown_strap_pin(strap), .link_up(link_up),
      .an_complete(an_c), .autoneg_enable_source(an_src), .soft_reset_active(sra),
      .local_loopback_enable(lpe), .soft_power_down(spd), .mac_side_isolate(msi));

   cmb_sta_model sta_u (.clk(clk), .mdc(mdc), .host_d(host_d), .host_en(host_en),
      .mdio_w(mdio_w));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIM) begin
         miscompares++;
         wrap_up();
      end
   end

   // ****************************************************
   // Tasks and expectations
   // ****************************************************
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   function automatic logic [15:0] ctrl_e(input logic r);
      return {r, loop_m, 1'b0, an_src, pd_m, iso_m, 2'b01, 8'h00};
   endfunction

   function automatic logic [15:0] st_e(input logic l);
      return 16'h1009 | {10'h000, an_c, 2'b00, l, 2'b00};
   endfunction

   task automatic fr(input logic c, input logic [1:0] op, input logic [4:0] pa,
                     input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic ta;
      sta_u.frame(c, op, pa, ra, wd, rd, ta);
      if (op[1] && pa == PA) chk("turnaround", {15'h0000, ta}, 16'h0000);
   endtask

   task automatic rd22(input logic [4:0] ra, output logic [15:0] d);
      fr(1'b1, `CMB_OP_RD, PA, ra, 16'h0000, d);
   endtask

   task automatic wr22(input logic [4:0] ra, input logic [15:0] w);
      logic [15:0] d;
      fr(1'b1, `CMB_OP_WR, PA, ra, w, d);
   endtask

   task automatic x45(input logic [4:0] dv, input logic [15:0] ad, input logic [1:0] op,
                      input logic [15:0] wd, output logic [15:0] d);
      fr(1'b0, 2'h0, PA, dv, ad, d);
      fr(1'b0, op, PA, dv, wd, d);
   endtask

   task automatic ctrl_chk();
      logic [15:0] d;
      rd22(`CMB_C22_CTRL, d);
      chk("ctrl", d, ctrl_e(1'b0));
      chk("pins", {13'h0000, lpe, spd, msi}, {13'h0000, loop_m, pd_m, iso_m});
   endtask

   task automatic hard_rst(input logic s);
      strap = s;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      loop_m = 1'b0;
      pd_m   = s;
      iso_m  = 1'b0;
   endtask

   task automatic sr_wait();
      for (int i = 0; i < SU + 50 && sra === 1'b1; i++) @(negedge clk);
      chk("reset_end", {15'h0000, sra}, 16'h0000);
      loop_m = 1'b0;
      pd_m   = strap;
      iso_m  = 1'b0;
      ctrl_chk();
   endtask

   // ****************************************************
   // Scenarios
   // ****************************************************
   initial begin
      logic [15:0] d, w;
      link_up = 1'b1;
      an_c    = 1'b1;
      an_src  = 1'b1;
      cyc     = 0;
      hard_rst(1'b1);
      ctrl_chk();
      rd22(`CMB_C22_ID_HI, d);
      chk("id_high", d, IDH);
      rd22(`CMB_C22_ID_LO, d);
      chk("id_low", d, IDL);
      rd22(`CMB_C22_IA_CTRL, d);
      chk("ia_ctrl", d, 16'h0000);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         w      = 16'($random(seed)) & 16'h7FFF;
         an_src = w[0];
         wr22(`CMB_C22_CTRL, w);
         loop_m = w[14];
         pd_m   = w[11];
         iso_m  = w[10];
         ctrl_chk();
         w = 16'($random(seed));
         wr22(i[0] ? `CMB_C22_IA_DATA : `CMB_C22_IA_CTRL, w);
         rd22(i[0] ? `CMB_C22_IA_DATA : `CMB_C22_IA_CTRL, d);
         chk("indirect", d, w);
      end
      an_src = 1'b1;
      $display("test random control done");
      fr(1'b1, `CMB_OP_WR, 5'h06, `CMB_C22_CTRL, 16'h4400, d);
      fr(1'b1, `CMB_OP_RD, 5'h06, `CMB_C22_CTRL, 16'h0000, d);
      chk("other_phy", d, 16'hFFFF);
      wr22(5'h07, 16'hFFFF);
      rd22(5'h07, d);
      chk("unmapped", d, 16'h0000);
      ctrl_chk();
      $display("test refused access done");
      rd22(`CMB_C22_STAT, d);
      rd22(`CMB_C22_STAT, d);
      chk("status", d, st_e(1'b1));
      link_up = 1'b0;
      repeat (3) @(negedge clk);
      link_up = 1'b1;
      rd22(`CMB_C22_STAT, d);
      chk("status_low", d, st_e(1'b0));
      rd22(`CMB_C22_STAT, d);
      chk("status_clr", d, st_e(1'b1));
      $display("test link latch done");
      rd22(`CMB_C22_CTRL, d);
      wr22(`CMB_C22_CTRL, (d & 16'hBBFF) | 16'h8000);
      chk("reset_run", {15'h0000, sra}, 16'h0001);
      wr22(`CMB_C22_CTRL, 16'h4400);
      rd22(`CMB_C22_CTRL, d);
      chk("reset_read", d & 16'hC400, 16'h8000);
      sr_wait();
      for (int i = 0; i < 5; i++) begin
         x45(DV[i], AD[i], `CMB_OP_WR, 16'h0001 << BT[i], d);
         chk("alias_run", {15'h0000, sra}, 16'h0001);
         rd22(`CMB_C22_CTRL, d);
         chk("alias_c22", d & 16'h8000, 16'h8000);
         sr_wait();
      end
      $display("test soft reset done");
      sta_u.half = 12;
      x45(5'h03, 16'h08E6, `CMB_OP_WR, 16'h4000, d);
      loop_m = 1'b1;
      ctrl_chk();
      rd22(`CMB_C22_CTRL, d);
      wr22(`CMB_C22_CTRL, d & 16'hF7FF);
      pd_m = 1'b0;
      x45(5'h1E, `CMB_A_VEND_PD, 2'h3, 16'h0000, d);
      chk("vend_pd", d & 16'h0001, 16'h0000);
      x45(5'h1E, `CMB_A_VEND_PD, `CMB_OP_WR, 16'h0001, d);
      pd_m = 1'b1;
      ctrl_chk();
      x45(5'h1E, 16'h8811, 2'h2, 16'h0000, d);
      chk("unmapped_45", d, 16'h0000);
      fr(1'b0, 2'h3, PA, 5'h1E, 16'h0000, d);
      chk("vend_pd_inc", d, {15'h0000, pd_m});
      $display("test mirrors done");
      hard_rst(1'b0);
      ctrl_chk();
      $display("test strap reset done");
      wrap_up();
   end
endmodule // tb_top
